// File: core/key_matrix_scanner.sv
// key matrix scanner with apb register access
`timescale 1ns/10ps
module key_matrix_scanner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [key_scan_pkg::ADDR_W-1:0] paddr,
  input wire logic [key_scan_pkg::DATA_W-1:0] pwdata,
  output logic pready,
  output logic [key_scan_pkg::DATA_W-1:0] prdata,
  output logic pslverr,
  input wire logic [key_scan_pkg::RET_W-1:0] key_return_inputs,
  output logic [key_scan_pkg::STROBE_N-1:0] strobe_segment_pins_n,
  input wire logic stop_mode,
  output logic stop_wake_req,
  output logic key_request_flag,
  output logic irq
);

  function automatic logic reg_hit(input logic [key_scan_pkg::ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    if (a == key_scan_pkg::ADDR_CTRL) begin
      hit = 1'b1;
    end else if (a == key_scan_pkg::ADDR_SAMPLE) begin
      hit = 1'b1;
    end else if (a == key_scan_pkg::ADDR_IRQ_STAT) begin
      hit = 1'b1;
    end else if (a == key_scan_pkg::ADDR_IRQ_MASK) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  function automatic logic [key_scan_pkg::RET_W-1:0] ret_mask(input logic [1:0] sel);
    logic [key_scan_pkg::RET_W-1:0] m;
    case (sel)
      key_scan_pkg::SEL_TWO: m = key_scan_pkg::MASK_TWO;
      key_scan_pkg::SEL_FOUR: m = key_scan_pkg::MASK_FOUR;
      key_scan_pkg::SEL_SIX: m = key_scan_pkg::MASK_SIX;
      default: m = key_scan_pkg::MASK_ALL;
    endcase
    return m;
  endfunction

  key_scan_pkg::ctrl_t ctrl_q;
  key_scan_pkg::ctrl_t ctrl_d;
  key_scan_pkg::capture_t cap_q;
  key_scan_pkg::capture_t cap_d;
  logic [key_scan_pkg::CNT_W-1:0] cnt_q;
  logic [key_scan_pkg::CNT_W-1:0] cnt_d;
  logic [key_scan_pkg::PHASE_W-1:0] phase_q;
  logic [key_scan_pkg::PHASE_W-1:0] phase_d;
  logic [key_scan_pkg::STROBE_N-1:0] strobe_q;
  logic [key_scan_pkg::STROBE_N-1:0] strobe_d;
  logic lock_q;
  logic lock_d;
  logic wake_q;
  logic wake_d;
  logic rd_armed_q;
  logic rd_armed_d;
  logic [key_scan_pkg::IRQ_W-1:0] stat_q;
  logic [key_scan_pkg::IRQ_W-1:0] stat_d;
  logic [key_scan_pkg::IRQ_W-1:0] mask_q;
  logic [key_scan_pkg::IRQ_W-1:0] mask_d;
  logic [key_scan_pkg::IRQ_W-1:0] events;
  logic irq_q;
  logic irq_d;
  logic [key_scan_pkg::DATA_W-1:0] rdata_q;
  logic [key_scan_pkg::DATA_W-1:0] rdata_d;

  logic [key_scan_pkg::RET_W-1:0] ret_levels;
  logic [key_scan_pkg::RET_W-1:0] en_mask;
  logic scan_en;
  logic tick;
  logic advance;
  logic pressed;
  logic detect;
  logic setup;
  logic wr;
  logic rd;
  logic rd_sample;
  logic rd_stat;
  logic [key_scan_pkg::CNT_W-1:0] cnt_view;

  key_return_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins(key_return_inputs),
    .levels(ret_levels)
  );

  scan_tick_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(scan_en),
    .tick(tick)
  );

  // scan engine
  always_comb begin
    scan_en = ~ctrl_q.scan_off;
    en_mask = ret_mask(ctrl_q.count_sel);
    // a tick still in flight when scanning stops must not move the counter
    advance = scan_en && tick && (phase_q == key_scan_pkg::PHASE_LAST);
    phase_d = phase_q;
    cnt_d = cnt_q;
    if (!scan_en) begin
      phase_d = key_scan_pkg::PHASE_FIRST;
    end else if (tick) begin
      phase_d = phase_q + 1'b1;
    end
    if (advance) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_comb begin
    // strobe low on the selected segment pin only
    if (scan_en) begin
      strobe_d = ~(key_scan_pkg::STROBE_N'(1) << cnt_d);
    end else begin
      strobe_d = '1;
    end
  end

  // key detection on the synchronised return lines
  always_comb begin
    pressed = |(~ret_levels & en_mask);
    // skip the tick right after a strobe change so the synchronised lines have settled
    detect = scan_en && tick && (phase_q != key_scan_pkg::PHASE_FIRST) && !lock_q && pressed;
  end

  // apb decode and register next values
  always_comb begin
    setup = psel && !penable;
    wr = psel && penable && pwrite;
    rd = psel && penable && !pwrite;
    rd_sample = rd && (paddr == key_scan_pkg::ADDR_SAMPLE);
    rd_stat = rd && (paddr == key_scan_pkg::ADDR_IRQ_STAT);
    events = '0;
    events[key_scan_pkg::IRQ_KEY_BIT] = detect;
    events[key_scan_pkg::IRQ_SWEEP_BIT] = advance && (cnt_q == '1);
  end

  // software writes to control and mask
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    if (wr && (paddr == key_scan_pkg::ADDR_CTRL)) begin
      ctrl_d.scan_off = pwdata[key_scan_pkg::CTRL_OFF_BIT];
      ctrl_d.count_sel = pwdata[key_scan_pkg::CTRL_SEL_MSB:key_scan_pkg::CTRL_SEL_LSB];
    end
    if (wr && (paddr == key_scan_pkg::ADDR_IRQ_MASK)) begin
      mask_d = pwdata[key_scan_pkg::IRQ_W-1:0];
    end
  end

  // detection lock and capture
  always_comb begin
    // only a read that started while locked returned the capture, so only it re-arms
    rd_armed_d = rd_armed_q;
    if (setup) begin
      rd_armed_d = lock_q;
    end
    // a detection in the same cycle as the re-arming read wins
    lock_d = lock_q;
    if (detect) begin
      lock_d = 1'b1;
    end else if (rd_sample && rd_armed_q) begin
      lock_d = 1'b0;
    end

    cap_d = cap_q;
    if (detect) begin
      cap_d.counter = cnt_q;
      cap_d.levels = ret_levels | ~en_mask;
    end
  end

  // sticky status, cleared by its read
  always_comb begin
    // only the bits the read returned are cleared; an event after the setup edge survives
    stat_d = (rd_stat ? (stat_q & ~rdata_q[key_scan_pkg::IRQ_W-1:0]) : stat_q) | events;
    irq_d = |(stat_d & mask_d);
  end

  // wake request lives only while the device is stopped
  always_comb begin
    wake_d = wake_q;
    if (detect && stop_mode) begin
      wake_d = 1'b1;
    end else if (!stop_mode) begin
      wake_d = 1'b0;
    end
  end

  // read data is taken in the setup cycle
  always_comb begin
    // counter is frozen in the view while locked so software sees the hit strobe
    cnt_view = lock_q ? cap_q.counter : cnt_q;
    rdata_d = rdata_q;
    if (setup) begin
      rdata_d = '0;
      if (paddr == key_scan_pkg::ADDR_CTRL) begin
        rdata_d[key_scan_pkg::CTRL_OFF_BIT] = ctrl_q.scan_off;
        rdata_d[key_scan_pkg::CTRL_SEL_MSB:key_scan_pkg::CTRL_SEL_LSB] = ctrl_q.count_sel;
        rdata_d[key_scan_pkg::CTRL_CNT_MSB:0] = cnt_view;
      end else if (paddr == key_scan_pkg::ADDR_SAMPLE) begin
        rdata_d[key_scan_pkg::RET_W-1:0] = cap_q.levels;
      end else if (paddr == key_scan_pkg::ADDR_IRQ_STAT) begin
        rdata_d[key_scan_pkg::IRQ_W-1:0] = stat_q;
      end else if (paddr == key_scan_pkg::ADDR_IRQ_MASK) begin
        rdata_d[key_scan_pkg::IRQ_W-1:0] = mask_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      phase_q <= key_scan_pkg::PHASE_FIRST;
      strobe_q <= '1;
    end else begin
      cnt_q <= cnt_d;
      phase_q <= phase_d;
      strobe_q <= strobe_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= key_scan_pkg::CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q <= '1;
      lock_q <= 1'b0;
      rd_armed_q <= 1'b0;
    end else begin
      cap_q <= cap_d;
      lock_q <= lock_d;
      rd_armed_q <= rd_armed_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
      mask_q <= key_scan_pkg::IRQ_MASK_RESET;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !reg_hit(paddr);
  assign prdata = rdata_q;
  assign strobe_segment_pins_n = strobe_q;
  assign key_request_flag = lock_q;
  assign stop_wake_req = wake_q;
  assign irq = irq_q;

endmodule

// File: core/key_scan_pkg.sv
// constants, register map and carrier types of the key matrix scanner
package key_scan_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned STROBE_TIME_NS = 244000;
  localparam int unsigned TICKS_PER_STROBE = 8;
  localparam int unsigned STROBE_CYCLES = STROBE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SCAN_TICK_CYCLES = STROBE_CYCLES / TICKS_PER_STROBE;
  localparam int unsigned DIV_W = 9;
  localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(SCAN_TICK_CYCLES - 1);

  // matrix geometry
  localparam int unsigned RET_W = 8;
  localparam int unsigned STROBE_N = 16;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned PHASE_W = 3;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 3'h7;
  localparam logic [PHASE_W-1:0] PHASE_FIRST = 3'h0;

  // apb
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h0f4;
  localparam logic [ADDR_W-1:0] ADDR_SAMPLE = 12'h0f8;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 12'h0fc;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h100;

  // control register layout
  localparam int unsigned CTRL_OFF_BIT = 7;
  localparam int unsigned CTRL_SEL_MSB = 6;
  localparam int unsigned CTRL_SEL_LSB = 5;
  localparam int unsigned CTRL_CNT_MSB = 3;
  localparam logic [2:0] CTRL_RESET = 3'h4;

  // interrupt status layout
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_KEY_BIT = 0;
  localparam int unsigned IRQ_SWEEP_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

  // input count selections
  localparam logic [1:0] SEL_TWO = 2'h0;
  localparam logic [1:0] SEL_FOUR = 2'h1;
  localparam logic [1:0] SEL_SIX = 2'h2;
  localparam logic [RET_W-1:0] MASK_TWO = 8'h03;
  localparam logic [RET_W-1:0] MASK_FOUR = 8'h0f;
  localparam logic [RET_W-1:0] MASK_SIX = 8'h3f;
  localparam logic [RET_W-1:0] MASK_ALL = 8'hff;

  typedef struct packed {
    logic scan_off;
    logic [1:0] count_sel;
  } ctrl_t;

  typedef struct packed {
    logic [CNT_W-1:0] counter;
    logic [RET_W-1:0] levels;
  } capture_t;

endpackage

// File: core/scan_tick_div.sv
// divider producing the one-cycle scan clock enable
`timescale 1ns/10ps
module scan_tick_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic tick
);

  logic [key_scan_pkg::DIV_W-1:0] div_q;
  logic [key_scan_pkg::DIV_W-1:0] div_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    div_d = div_q;
    tick_d = 1'b0;
    if (!run) begin
      div_d = '0;
    end else if (div_q == key_scan_pkg::TICK_LAST) begin
      div_d = '0;
      tick_d = 1'b1;
    end else begin
      div_d = div_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

// File: core/key_return_sync.sv
// two-stage synchronisers for the key return pins
`timescale 1ns/10ps
module key_return_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [key_scan_pkg::RET_W-1:0] pins,
  output logic [key_scan_pkg::RET_W-1:0] levels
);

  genvar i;
  generate
    for (i = 0; i < key_scan_pkg::RET_W; i++) begin : g_sync
      logic meta_q;
      logic sync_q;
      // idle level of a return line is high (no key)
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
        end else begin
          meta_q <= pins[i];
          sync_q <= meta_q;
        end
      end
      assign levels[i] = sync_q;
    end
  endgenerate

endmodule

// File: sim/key_scan_monitor.sv
// concurrent checks on the key matrix scanner ports
`timescale 1ns/10ps
module key_scan_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [key_scan_pkg::ADDR_W-1:0] paddr,
  input wire logic [key_scan_pkg::DATA_W-1:0] pwdata,
  input wire logic [key_scan_pkg::STROBE_N-1:0] strobe_segment_pins_n,
  input wire logic stop_mode,
  input wire logic stop_wake_req,
  input wire logic key_request_flag
);
  localparam int STAND = key_scan_pkg::STROBE_CYCLES - 1;
  logic [15:0] sp;
  logic [15:0] prev_q;
  logic [15:0] age_q;
  logic [15:0] age_d;
  logic ctrl_wr;
  logic data_rd;
  logic step;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  assign sp = strobe_segment_pins_n;
  assign ctrl_wr = psel && penable && pwrite && paddr == key_scan_pkg::ADDR_CTRL;
  assign data_rd = psel && penable && !pwrite && paddr == key_scan_pkg::ADDR_SAMPLE;
  // transitions from or to the idle pattern are scan on/off, not strobe steps
  assign step = sp != prev_q && prev_q != '1 && sp != '1;
  always_comb begin
    age_d = (sp != prev_q) ? 16'h0 : age_q + 16'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= '1;
      age_q <= '0;
    end else begin
      prev_q <= sp;
      age_q <= age_d;
    end
  end
  strobe_onehot_a: assert property ($onehot0(~sp))
    else $error("more than one strobe active");
  strobe_order_a: assert property (step |-> sp == {prev_q[14:0], prev_q[15]})
    else $error("strobe did not step to the next pin");
  strobe_stand_a: assert property (step |-> age_q == STAND)
    else $error("strobe stood for a wrong time");
  scan_on_a: assert property (ctrl_wr && !pwdata[7] |-> ##[1:2] sp != '1)
    else $error("scanning did not start");
  scan_off_a: assert property (ctrl_wr && pwdata[7] |-> ##[1:2] sp == '1)
    else $error("scanning did not stop");
  flag_hold_a: assert property (key_request_flag && !data_rd |=> key_request_flag)
    else $error("key flag dropped without key data read");
  flag_scan_a: assert property ($rose(key_request_flag) |-> $past(sp) != '1)
    else $error("key flag set while not scanning");
  wake_clear_a: assert property (!stop_mode |=> !stop_wake_req)
    else $error("wake request outside stop");
  wake_cause_a: assert property ($rose(stop_wake_req) |-> $rose(key_request_flag))
    else $error("wake request without key detection");
endmodule

bind key_matrix_scanner key_scan_monitor u_key_scan_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .strobe_segment_pins_n, .stop_mode, .stop_wake_req, .key_request_flag);

// File: sim/key_matrix_model.sv
// passive key switch matrix with pulled-up return lines
`timescale 1ns/10ps
module key_matrix_model (
  input wire logic [15:0] strobe_n,
  input wire logic press_on,
  input wire logic [3:0] press_row,
  input wire logic [2:0] press_col,
  output logic [7:0] returns
);
  // external pull-ups keep open lines high, the device's own stay off
  always_comb begin
    returns = 8'hff;
    if (press_on && !strobe_n[press_row]) begin
      returns[press_col] = 1'b0;
    end
  end
endmodule

// File: sim/testbench.sv
// self-checking bench for the key matrix scanner
`timescale 1ns/10ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, stop_mode, wake, flag, irq, press_on;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] ret;
  logic [15:0] sp;
  logic [3:0] row;
  logic [2:0] col;
  int checks, mismatches;
  always #50 pclk = ~pclk;
  key_matrix_scanner u_key_matrix_scanner (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .key_return_inputs(ret), .strobe_segment_pins_n(sp), .stop_mode,
    .stop_wake_req(wake), .key_request_flag(flag), .irq);
  key_matrix_model u_key_matrix_model (.strobe_n(sp), .press_on, .press_row(row), .press_col(col),
    .returns(ret));
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task press_next(input logic [2:0] k);
    apb(1'b0, key_scan_pkg::ADDR_CTRL, 32'h0);
    row <= rd[3:0] + 4'h1;
    col <= k;
    press_on <= 1'b1;
  endtask
  task wait_low(input logic [3:0] n);
    for (int i = 0; i < 45000 && sp[n] !== 1'b0; i++) @(posedge pclk);
  endtask
  task final_report;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #9500000;
    mismatches++;
    final_report();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, stop_mode, press_on, paddr, pwdata, row, col} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, key_scan_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h80);
    apb(1'b0, key_scan_pkg::ADDR_SAMPLE, 32'h0);
    check(rd, 32'hff);
    apb(1'b0, 12'h200, 32'h0);
    check(32'(err), 32'h1);
    check(rd, 32'h0);
    apb(1'b1, key_scan_pkg::ADDR_IRQ_MASK, 32'h1);
    apb(1'b0, key_scan_pkg::ADDR_IRQ_MASK, 32'h0);
    check(rd, 32'h1);
    // two inputs only: a press on the third line stays unseen
    apb(1'b1, key_scan_pkg::ADDR_CTRL, 32'h0);
    press_next(3'd2);
    wait_low(rd[3:0] + 4'h2);
    check(flag, 1'b0);
    press_on <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, key_scan_pkg::ADDR_CTRL, 32'(s) << 5);
      stop_mode <= (s == 3);
      press_next(3'(2 * s + 1));
      for (int i = 0; i < 8000 && flag !== 1'b1; i++) @(posedge pclk);
      check(flag, 1'b1);
      press_on <= 1'b0;
      apb(1'b0, key_scan_pkg::ADDR_CTRL, 32'h0);
      check(rd, {24'h0, 1'b0, 2'(s), 1'b0, row});
      check({wake, irq}, {s == 3, 1'b1});
      stop_mode <= 1'b0;
      apb(1'b0, key_scan_pkg::ADDR_IRQ_STAT, 32'h0);
      check(rd & 32'h1, 32'h1);
      apb(1'b0, key_scan_pkg::ADDR_SAMPLE, 32'h0);
      check(rd, 32'hff ^ (32'h1 << col));
      @(posedge pclk);
      check({flag, irq}, 2'b00);
    end
    wait_low(4'hf);
    wait_low(4'h0);
    apb(1'b0, key_scan_pkg::ADDR_IRQ_STAT, 32'h0);
    check(rd & 32'h2, 32'h2);
    // scanning off: strobes idle, counter holds across more than one strobe time
    apb(1'b1, key_scan_pkg::ADDR_CTRL, 32'h80);
    apb(1'b0, key_scan_pkg::ADDR_CTRL, 32'h0);
    check(rd & 32'hf0, 32'h80);
    check(32'(sp), 32'hffff);
    row <= rd[3:0];
    repeat (2500) @(posedge pclk);
    apb(1'b0, key_scan_pkg::ADDR_CTRL, 32'h0);
    check(rd & 32'hf, 32'(row));
    final_report();
  end
endmodule
